// file: sim/byte_sink.sv
/*
  model of the frame buffer that takes the packed bytes; random stalls.
  assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module byte_sink (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic stall_i,
  output logic      byte_ready_o
);
  int seed = 32'h1234ABCD;

  // takes a byte two cycles in three, never in the cycle after one with stall_i high
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) byte_ready_o <= 1'b0;
    else byte_ready_o <= !stall_i && ($random(seed) % 3 != 0);
  end
endmodule // byte_sink

`default_nettype wire

// file: sim/packer_sva.sv
/*
  assertions on the packer ports.
  assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module packer_sva (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic [2:0] format_i,
  input wire logic [1:0] depth_i,
  input wire logic [9:0] gain_req_i,
  input wire logic [5:0] gain_step_o,
  input wire logic       cfg_error_o,
  input wire logic       pix_valid_i,
  input wire logic       pix_ready_o,
  input wire logic       byte_valid_o,
  input wire logic       byte_ready_i,
  input wire logic [7:0] byte_data_o,
  input wire logic [1:0] byte_colour_o
);
  logic bad;
  logic two;
  always_comb begin
    two = format_i == 3'h1 || format_i == 3'h3 || format_i == 3'h4;
    bad = !((format_i == 3'h0 || format_i == 3'h2 || format_i == 3'h5)
      && depth_i <= 2'h2
      || two && depth_i == (format_i == 3'h3 ? 2'h1 : 2'h2));
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence stalled;
    byte_valid_o && !byte_ready_i;
  endsequence
  sequence held;
    byte_valid_o && $stable(byte_data_o) && $stable(byte_colour_o);
  endsequence
  a_gain_round: assert property (
    !$past(reset_i) |-> gain_step_o ==
      6'((11'($past(gain_req_i)) + 11'h00C) / 11'h019))
    else $error("gain step wrong");
  a_cfg_legal: assert property (
    !$past(reset_i) |-> cfg_error_o == $past(bad))
    else $error("config error flag wrong");
  a_byte_hold: assert property (stalled |=> held)
    else $error("byte changed while stalled");
  a_pair_gap: assert property (
    pix_valid_i && pix_ready_o && two && !bad |=> !pix_ready_o)
    else $error("second byte not reserved");
  a_gray_tag: assert property (
    byte_valid_o && format_i <= 3'h1 |-> byte_colour_o == 2'h0)
    else $error("grey byte carries colour");
  a_mosaic_tag: assert property (
    byte_valid_o && format_i >= 3'h2 && format_i <= 3'h5
      |-> byte_colour_o != 2'h0)
    else $error("mosaic byte without colour");
  a_illegal_mute: assert property (
    cfg_error_o && !byte_valid_o |=> !byte_valid_o)
    else $error("bytes from illegal config");
  a_reset_empty: assert property (
    $fell(reset_i) |-> !byte_valid_o && pix_ready_o)
    else $error("not empty after reset");
endmodule // packer_sva

bind pixel_format_packer packer_sva u_sva (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .format_i(format_i),
  .depth_i(depth_i), .gain_req_i(gain_req_i), .gain_step_o(gain_step_o),
  .cfg_error_o(cfg_error_o), .pix_valid_i(pix_valid_i),
  .pix_ready_o(pix_ready_o), .byte_valid_o(byte_valid_o),
  .byte_ready_i(byte_ready_i), .byte_data_o(byte_data_o),
  .byte_colour_o(byte_colour_o));

`default_nettype wire

// file: sim/tb.sv
/*
  self-checking bench for the packer: frames in every format, stalls.
  assumes the packer, its fifo and the byte sink model are compiled.
*/
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic       sys_clk_i = 0, reset_i = 1, stall = 0;
  logic [2:0] format_i = 0;
  logic [1:0] depth_i = 0;
  logic [9:0] gain_req_i = 10'h064;
  logic       pix_valid_i = 0, pix_sof_i = 0, pix_eol_i = 0;
  logic [11:0] pix_data_i = 0;
  wire logic [5:0] gain_step_o;
  wire logic  cfg_error_o, pix_ready_o, byte_valid_o, byte_ready_i;
  wire logic [7:0] byte_data_o;
  wire logic [1:0] byte_colour_o;
  int num_errors = 0, checks = 0, seed = 32'he5e54cc2;
  logic [9:0] exp_q[$], got_q[$];
  logic [4:0] tbl[14] = '{5'h00, 5'h01, 5'h06, 5'h08, 5'h0A, 5'h0D,
                          5'h12, 5'h15, 5'h14, 5'h04, 5'h0E, 5'h11,
                          5'h1A, 5'h03};

  always #2.5 sys_clk_i = ~sys_clk_i;

  pixel_format_packer uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .format_i(format_i), .depth_i(depth_i), .gain_req_i(gain_req_i),
    .gain_step_o(gain_step_o), .cfg_error_o(cfg_error_o),
    .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
    .pix_data_i(pix_data_i), .pix_sof_i(pix_sof_i), .pix_eol_i(pix_eol_i),
    .byte_valid_o(byte_valid_o), .byte_ready_i(byte_ready_i),
    .byte_data_o(byte_data_o), .byte_colour_o(byte_colour_o));
  byte_sink sink (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .stall_i(stall), .byte_ready_o(byte_ready_i));

  always @(posedge sys_clk_i)
    if (!reset_i && byte_valid_o && byte_ready_i)
      got_q.push_back({byte_colour_o, byte_data_o});

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // colour expected at row r, column c
  function automatic logic [1:0] tag(input logic [2:0] f, input int r, c);
    logic [1:0] t;
    t = r[0] ? (c[0] ? 2'h3 : 2'h2) : (c[0] ? 2'h2 : 2'h1);
    if (f == pixel_format_pkg::FMT_MOSAIC_GREEN_RED_BYTE)
      t = r[0] ? (c[0] ? 2'h2 : 2'h3) : (c[0] ? 2'h1 : 2'h2);
    if (f <= 3'h1) t = pixel_format_pkg::COLOUR_GRAY;
    return t;
  endfunction

  task automatic frame(input logic [2:0] f, input logic [1:0] d,
                       input int h, w, g);
    logic [11:0] s;
    logic acc, ok, two;
    two = f == 3'h1 || f == 3'h3 || f == 3'h4;
    ok = ((f == 3'h0 || f == 3'h2 || f == 3'h5) && d <= 2'h2)
      || (f == 3'h3 && d == 2'h1) || (two && f != 3'h3 && d == 2'h2);
    @(posedge sys_clk_i);
    format_i <= f;
    depth_i <= d;
    gain_req_i <= 10'(g);
    repeat (3) @(posedge sys_clk_i);
    check(16'(cfg_error_o), 16'(!ok));
    check(16'(gain_step_o), 16'((g + 12) / 25));
    for (int r = 0; r < h; r++) for (int c = 0; c < w; c++) begin
      s = 12'($random(seed));
      // ten-bit mosaic gets junk above bit 9 to prove it is cleared
      if (f != 3'h3) s = s & ((12'h001 << (8 + 2 * d)) - 12'h001);
      if (ok && two) begin
        exp_q.push_back({tag(f, r, c), s[7:0]});
        exp_q.push_back({tag(f, r, c), (f == 3'h3 ? {6'h00, s[9:8]}
                                                  : {4'h0, s[11:8]})});
      end else if (ok) exp_q.push_back({tag(f, r, c), 8'(s >> (2 * d))});
      pix_valid_i <= 1'b1;
      pix_data_i <= s;
      pix_sof_i <= r == 0 && c == 0;
      pix_eol_i <= c == w - 1;
      do begin
        @(negedge sys_clk_i);
        acc = pix_ready_o;
        @(posedge sys_clk_i);
      end while (!acc);
      if ($random(seed) % 4 == 0) begin
        pix_valid_i <= 1'b0;
        @(posedge sys_clk_i);
      end
    end
    pix_valid_i <= 1'b0;
    for (int i = 0; i < 400 && got_q.size() < exp_q.size(); i++)
      @(posedge sys_clk_i);
    repeat (8) @(posedge sys_clk_i);
    check(16'(got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      check(16'(got_q[i]), 16'(exp_q[i]));
    exp_q.delete();
    got_q.delete();
    $display("frame format %0d depth %0d done", f, d);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    stall <= 1'b1;
    fork
      frame(3'h0, 2'h2, 4, 5, 12);
      begin
        repeat (60) @(negedge sys_clk_i);
        check(16'(pix_ready_o), 16'h0000);
        @(posedge sys_clk_i);
        stall <= 1'b0;
      end
    join
    frame(3'h1, 2'h2, 2, 3, 13);
    for (int i = 0; i < 14; i++)
      frame(tbl[i][4:2], tbl[i][1:0], 3, 2 + $unsigned($random(seed)) % 4,
            $unsigned($random(seed)) % 1024);
    report_and_stop();
  end

  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule // tb

`default_nettype wire

// file: verilog/byte_fifo.sv
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_q != (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_q];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // byte_fifo

`default_nettype wire

// file: verilog/pixel_format_packer.sv
/*
  packs sensor samples into a byte stream in the selected pixel format,
  tags each byte with its mosaic colour and quantises the amplifier gain.
  assumes the sensor stream and the byte sink run on sys_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none


module pixel_format_packer #(
  parameter int FIFO_DEPTH = pixel_format_pkg::FIFO_DEPTH
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [2:0]  format_i,
  input  wire logic [1:0]  depth_i,
  input  wire logic [pixel_format_pkg::GAIN_REQ_W-1:0]  gain_req_i,
  output logic      [pixel_format_pkg::GAIN_STEP_W-1:0] gain_step_o,
  output logic             cfg_error_o,
  input  wire logic        pix_valid_i,
  output logic             pix_ready_o,
  input  wire logic [pixel_format_pkg::SAMPLE_W-1:0] pix_data_i,
  input  wire logic        pix_sof_i,
  input  wire logic        pix_eol_i,
  output logic             byte_valid_o,
  input  wire logic        byte_ready_i,
  output logic      [7:0]  byte_data_o,
  output logic      [1:0]  byte_colour_o
);

  typedef enum logic [0:0] {ST_TAKE, ST_HIGH} pack_state_e;

  pack_state_e state_q;
  logic        col_odd_q;
  logic        row_odd_q;
  logic [15:0] word_q;
  logic [1:0]  colour_q;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [9:0]  fifo_in_data;
  logic [9:0]  fifo_out_data;
  logic        take;
  logic        legal;
  logic        two_bytes;
  logic [15:0] word_now;
  logic [1:0]  colour_now;
  logic        row_now;

  function automatic logic depth_ok(input logic [2:0] f,
                                    input logic [1:0] d);
    case (f)
      pixel_format_pkg::FMT_MOSAIC_RED_FIRST_TEN:
        depth_ok = (d == pixel_format_pkg::SENSOR_DEPTH_TEN);
      pixel_format_pkg::FMT_GRAY_TWELVE_IN_TWO_BYTES,
      pixel_format_pkg::FMT_MOSAIC_RED_FIRST_TWELVE:
        depth_ok = (d == pixel_format_pkg::SENSOR_DEPTH_TWELVE);
      pixel_format_pkg::FMT_GRAY_ONE_BYTE,
      pixel_format_pkg::FMT_MOSAIC_RED_FIRST_BYTE,
      pixel_format_pkg::FMT_MOSAIC_GREEN_RED_BYTE:
        depth_ok = (d == pixel_format_pkg::SENSOR_DEPTH_EIGHT) ||
                   (d == pixel_format_pkg::SENSOR_DEPTH_TEN) ||
                   (d == pixel_format_pkg::SENSOR_DEPTH_TWELVE);
      default:
        depth_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [1:0] colour_of(input logic [2:0] f,
                                           input logic row,
                                           input logic col);
    case (f)
      pixel_format_pkg::FMT_MOSAIC_RED_FIRST_BYTE,
      pixel_format_pkg::FMT_MOSAIC_RED_FIRST_TEN,
      pixel_format_pkg::FMT_MOSAIC_RED_FIRST_TWELVE:
        if (!row) begin
          colour_of = col ? pixel_format_pkg::COLOUR_GREEN
                          : pixel_format_pkg::COLOUR_RED;
        end else begin
          colour_of = col ? pixel_format_pkg::COLOUR_BLUE
                          : pixel_format_pkg::COLOUR_GREEN;
        end
      pixel_format_pkg::FMT_MOSAIC_GREEN_RED_BYTE:
        if (!row) begin
          colour_of = col ? pixel_format_pkg::COLOUR_RED
                          : pixel_format_pkg::COLOUR_GREEN;
        end else begin
          colour_of = col ? pixel_format_pkg::COLOUR_GREEN
                          : pixel_format_pkg::COLOUR_BLUE;
        end
      default:
        colour_of = pixel_format_pkg::COLOUR_GRAY;
    endcase
  endfunction

  function automatic logic [15:0] word_of(input logic [2:0] f,
                                          input logic [1:0] d,
                                          input logic [11:0] s);
    case (f)
      pixel_format_pkg::FMT_GRAY_TWELVE_IN_TWO_BYTES,
      pixel_format_pkg::FMT_MOSAIC_RED_FIRST_TWELVE:
        word_of = {4'h0, s};
      pixel_format_pkg::FMT_MOSAIC_RED_FIRST_TEN:
        word_of = {6'h00, s[9:0]};
      default:
        case (d) // keep the top eight bits of the sample
          pixel_format_pkg::SENSOR_DEPTH_TEN:    word_of = {8'h00, s[9:2]};
          pixel_format_pkg::SENSOR_DEPTH_TWELVE: word_of = {8'h00, s[11:4]};
          default:                               word_of = {8'h00, s[7:0]};
        endcase
    endcase
  endfunction

  assign legal      = depth_ok(format_i, depth_i);
  assign two_bytes  =
    (format_i == pixel_format_pkg::FMT_GRAY_TWELVE_IN_TWO_BYTES) ||
    (format_i == pixel_format_pkg::FMT_MOSAIC_RED_FIRST_TEN) ||
    (format_i == pixel_format_pkg::FMT_MOSAIC_RED_FIRST_TWELVE);
  // a start of frame restarts the mosaic phase at the upper-left pixel
  assign row_now    = pix_sof_i ? 1'b0 : row_odd_q;
  assign word_now   = word_of(format_i, depth_i, pix_data_i);
  assign colour_now = colour_of(format_i, row_now,
                                pix_sof_i ? 1'b0 : col_odd_q);

  // illegal combinations drain the input so the sensor never hangs
  assign pix_ready_o = (state_q == ST_TAKE) && (fifo_in_ready || !legal);
  assign take        = pix_valid_i && pix_ready_o;

  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data  = {colour_now, word_now[7:0]};
    if (state_q == ST_HIGH) begin
      fifo_in_valid = 1'b1;
      fifo_in_data  = {colour_q, word_q[15:8]};
    end else if (pix_valid_i && legal) begin
      fifo_in_valid = 1'b1; // low byte goes first
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q  <= ST_TAKE;
      word_q   <= 16'h0000;
      colour_q <= pixel_format_pkg::COLOUR_GRAY;
    end else begin
      case (state_q)
        ST_TAKE:
          if (take && legal && two_bytes) begin
            state_q  <= ST_HIGH;
            word_q   <= word_now;
            colour_q <= colour_now;
          end
        ST_HIGH:
          if (fifo_in_ready) begin
            state_q <= ST_TAKE;
          end
        default:
          state_q <= ST_TAKE;
      endcase
    end
  end

  // raster position: column parity per pixel, line parity per line
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      col_odd_q <= 1'b0;
      row_odd_q <= 1'b0;
    end else if (take) begin
      if (pix_eol_i) begin
        col_odd_q <= 1'b0;
        row_odd_q <= !row_now;
      end else begin
        col_odd_q <= pix_sof_i ? 1'b1 : !col_odd_q;
        row_odd_q <= row_now;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_error_o <= 1'b0;
    end else begin
      cfg_error_o <= !legal;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gain_step_o <= pixel_format_pkg::GAIN_STEP_RESET;
    end else begin
      // one spare bit so the rounding sum cannot wrap near full scale
      gain_step_o <= pixel_format_pkg::GAIN_STEP_W'(
        ({1'b0, gain_req_i} + {1'b0, pixel_format_pkg::GAIN_HALF_STEP}) /
        {1'b0, pixel_format_pkg::GAIN_FINE_PER_STEP});
    end
  end

  byte_fifo #(
    .WIDTH (10),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (byte_valid_o),
    .out_ready_i (byte_ready_i),
    .out_data_o  (fifo_out_data)
  );

  assign byte_data_o   = fifo_out_data[7:0];
  assign byte_colour_o = fifo_out_data[9:8];

endmodule // pixel_format_packer

`default_nettype wire

// file: verilog/pixel_format_pkg.sv
/*
  constants for the pixel format packer: format and depth codes,
  colour tags, gain step sizes, reset values.
  assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package pixel_format_pkg;

  // output pixel formats, as driven on format_i
  localparam logic [2:0] FMT_GRAY_ONE_BYTE           = 3'h0;
  localparam logic [2:0] FMT_GRAY_TWELVE_IN_TWO_BYTES = 3'h1;
  localparam logic [2:0] FMT_MOSAIC_RED_FIRST_BYTE   = 3'h2;
  localparam logic [2:0] FMT_MOSAIC_RED_FIRST_TEN    = 3'h3;
  localparam logic [2:0] FMT_MOSAIC_RED_FIRST_TWELVE = 3'h4;
  localparam logic [2:0] FMT_MOSAIC_GREEN_RED_BYTE   = 3'h5;

  // sensor depth, as driven on depth_i
  localparam logic [1:0] SENSOR_DEPTH_EIGHT  = 2'h0;
  localparam logic [1:0] SENSOR_DEPTH_TEN    = 2'h1;
  localparam logic [1:0] SENSOR_DEPTH_TWELVE = 2'h2;

  // colour tag that travels with each output byte
  localparam logic [1:0] COLOUR_GRAY  = 2'h0;
  localparam logic [1:0] COLOUR_RED   = 2'h1;
  localparam logic [1:0] COLOUR_GREEN = 2'h2;
  localparam logic [1:0] COLOUR_BLUE  = 2'h3;

  // gain in hundredths of x; coarse step is 0.25x
  localparam int         GAIN_REQ_W    = 10;
  localparam int         GAIN_STEP_W   = 6;
  localparam logic [GAIN_REQ_W-1:0] GAIN_FINE_PER_STEP = 10'h019;
  localparam logic [GAIN_REQ_W-1:0] GAIN_HALF_STEP     = 10'h00C;
  localparam logic [GAIN_STEP_W-1:0] GAIN_STEP_RESET   = 6'h04;

  localparam int         FIFO_DEPTH    = 16;
  localparam int         SAMPLE_W      = 12;

endpackage

`default_nettype wire
